// [pscr_pkg.sv]
// Constants shared by the PLL scan cache reconfiguration block.
// Assumes one system clock and an APB master for software access.
// How it works
// - Scan data output changes only while the cache is being applied.
// - ROM load steps the address upward from zero to the chain length.
// - The ROM address means nothing unless ROM fetch active is high.
// - Each ROM address is held for exactly one clock.
// - While ROM fetch active is high the address is valid.
// - Optional ROM fill runs once after power-up, not after every reset.
// - Oldest family chain is 288 bits (long) or 192 bits (short).
// - Cache resets to zero unless an initial image is given.
// - Chain sizes: 234 top/bottom, 180 side, 144 low-cost.
// - Newer family counter codes: N, M, CP/LF, VCO, C0-C9; 14-15 illegal.
// - Newer family params: high, low, bypass, mode; 111 nominal for M/N.
// - Even nominal count splits equally into high and low.
// - Odd nominal: high=(v+1)/2, low=v-high, odd bit set.
// - Nominal count of one sets the bypass bit.
// - Intermediate family counter codes: N, M, CP/LF, C0-C5; rest illegal.
// - Intermediate params: counts, phase, bypass, odd; CP/LF current/R/C.
// - Intermediate widths: 9-bit M/N, 8-bit outputs, 2-bit phase.
// - Oldest family: M, N, G0-G3, L0-L1, E1-E4 (E on long only).
// - Oldest params: 9-bit counts, 4-bit delay, 1-bit bypass and odd.
// - Edge after a ROM load request asserts fetch active.
// - Address restart pulse keeps the ROM bit fetched on the next clock out of the cache.
// - Busy rises the edge after a request and holds until done.
package pscr_pkg;
  // APB byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0C;
  // CTRL bits
  localparam int B_RD = 0;
  localparam int B_WR = 1;
  localparam int B_APPLY = 2;
  localparam int B_ROM = 3;
  localparam int B_RESTART = 4;
  localparam int B_ARST = 5;
  // CFG fields
  localparam int F_TYPE = 0;
  localparam int F_PARAM = 4;
  localparam int F_DATA = 8;
  // Families and variants
  localparam logic [1:0] FAM_NEW = 2'h0;
  localparam logic [1:0] FAM_MID = 2'h1;
  localparam logic [1:0] FAM_OLD = 2'h2;
  localparam logic [1:0] VAR_TB = 2'h0;
  localparam logic [1:0] VAR_SIDE = 2'h1;
  localparam logic [1:0] VAR_LOW = 2'h2;
  localparam logic [1:0] CH_UNUSED = 2'h0;
  localparam logic [1:0] CH_LONG = 2'h1;
  localparam logic [1:0] CH_SHORT = 2'h2;
  // Chain lengths
  localparam int CACHE_W = 384;
  localparam logic [8:0] LEN_TB = 9'h0EA;
  localparam logic [8:0] LEN_SIDE = 9'h0B4;
  localparam logic [8:0] LEN_LOW = 9'h090;
  localparam logic [8:0] LEN_LONG = 9'h120;
  localparam logic [8:0] LEN_SHORT = 9'h0C0;
  localparam logic [8:0] LEN_MID = 9'h180;
  // Cache layout: one 24-bit slot per counter code
  localparam logic [8:0] SLOT_W = 9'h018;
  localparam logic [8:0] OF_P0 = 9'h000;
  localparam logic [8:0] OF_P1 = 9'h009;
  localparam logic [8:0] OF_P2 = 9'h012;
  localparam logic [8:0] OF_P4 = 9'h016;
  localparam logic [8:0] OF_P5 = 9'h017;
  // ROM pipeline latency and tail
  localparam logic [1:0] ROM_LAT = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_RD = 4'h1, ST_WR = 4'h2, ST_SHIFT = 4'h3,
    ST_UPD = 4'h4, ST_WAITD = 4'h5, ST_RST = 4'h6, ST_ROM = 4'h7,
    ST_TAIL = 4'h8
  } pscr_state_type;
endpackage

// [pscr_top.sv]
// PLL scan cache reconfiguration: APB registers, cache, ROM loader, scan shifter.
// Assumes the PLL scan port and serial ROM run on sys_clk_i; scandone is async.
`timescale 1ns/1ps
`default_nettype none
module pscr_top
  import pscr_pkg::*;
#(
  parameter logic [1:0] FAMILY = FAM_NEW,
  parameter logic [1:0] VARIANT = VAR_TB,
  parameter logic [1:0] SCAN_CHAIN = CH_UNUSED,
  parameter bit INIT_FROM_ROM = 1'b0,
  parameter logic [CACHE_W-1:0] CACHE_INIT = '0
) (
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // PLL scan port
  output logic pll_scandata_o,
  output logic pll_scanclk_o,
  output logic pll_scanclkena_o,
  output logic pll_configupdate_o,
  output logic pll_areset_o,
  input wire logic pll_scandone_i,
  // Serial ROM
  input wire logic rom_data_i,
  output logic [8:0] rom_addr_o,
  output logic rom_active_o
);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [8:0] chain_len();
    if (FAMILY == FAM_OLD)
      return (SCAN_CHAIN == CH_LONG) ? LEN_LONG : LEN_SHORT;
    if (FAMILY == FAM_MID)
      return LEN_MID;
    case (VARIANT)
      VAR_TB: return LEN_TB;
      VAR_SIDE: return LEN_SIDE;
      default: return LEN_LOW;
    endcase
  endfunction

  // Returns {legal, bit offset, width} of one cache field
  function automatic logic [13:0] decode(input logic [3:0] t, input logic [2:0] p);
    logic [8:0] base;
    logic [8:0] ofs;
    logic [3:0] w;
    logic ok;
    base = 9'((t * SLOT_W));
    ofs = 9'h000;
    w = 4'h0;
    ok = 1'b0;
    case (FAMILY)
      FAM_NEW: begin
        ok = (t < 4'hE);
        case (p)
          3'h0: begin ofs = OF_P0; w = (t == 4'h2) ? 4'h3 : ((t == 4'h3) ? 4'h1 : 4'h8); end
          3'h1: begin ofs = OF_P1; w = (t == 4'h2) ? 4'h5 : 4'h8; ok = ok && t != 4'h3; end
          3'h2: begin ofs = OF_P2; w = 4'h2; ok = ok && t == 4'h2; end
          3'h4: begin ofs = OF_P4; w = 4'h1; ok = ok && t != 4'h3; end
          3'h5: begin ofs = OF_P5; w = (t == 4'h2) ? 4'h5 : 4'h1; ok = ok && t != 4'h3; end
          3'h7: begin ofs = OF_P0; w = 4'h9; ok = ok && t < 4'h2; end
          default: ok = 1'b0;
        endcase
      end
      FAM_MID: begin
        ok = (t != 4'h3) && (t < 4'hA);
        case (p)
          3'h0: begin ofs = OF_P0; w = (t < 4'h2) ? 4'h9 : ((t == 4'h2) ? 4'h4 : 4'h8); end
          3'h1: begin ofs = OF_P1; w = (t < 4'h2) ? 4'h9 : ((t == 4'h2) ? 4'h6 : 4'h8); end
          3'h2: begin ofs = OF_P2; w = 4'h2; end
          3'h4: begin ofs = OF_P4; w = 4'h1; ok = ok && t != 4'h2; end
          3'h5: begin ofs = OF_P5; w = 4'h1; ok = ok && t != 4'h2; end
          default: ok = 1'b0;
        endcase
      end
      default: begin
        ok = (t < 4'h2) || (t[3:2] == 2'h1) || (t[3:1] == 3'h4) ||
             (t[3:2] == 2'h3 && SCAN_CHAIN == CH_LONG);
        case (p)
          3'h0: begin ofs = OF_P0; w = 4'h9; end
          3'h1: begin ofs = OF_P1; w = 4'h9; end
          3'h2: begin ofs = OF_P2; w = 4'h4; end
          3'h4: begin ofs = OF_P4; w = 4'h1; end
          3'h5: begin ofs = OF_P5; w = 4'h1; end
          default: ok = 1'b0;
        endcase
      end
    endcase
    return {ok, 9'(base + ofs), w};
  endfunction

  localparam logic [8:0] LEN = chain_len();

  ////////////////////////////////////////////////////////////////////////
  pscr_state_type st_r;
  logic [CACHE_W-1:0] cache_r;
  logic [3:0] type_r;
  logic [2:0] param_r;
  logic [8:0] wdata_r;
  logic [8:0] dout_r;
  logic arst_in_r;
  logic [8:0] cnt_r;
  logic [8:0] rom_ptr_r;
  logic [1:0] tail_r;
  logic [8:0] addr_d1_r;
  logic [8:0] addr_d2_r;
  logic vld_d1_r;
  logic vld_d2_r;
  logic done_s1_r;
  logic done_s2_r;
  logic done_s3_r;
  logic pu_done_r = 1'b0;
  logic scanclk_r;
  logic scandata_r;
  logic areset_r;
  logic restart_pend_r;

  logic apb_wr;
  logic ctrl_wr;
  logic idle_go;
  logic [13:0] dec;
  logic nom_op;
  logic [8:0] hc;
  logic [8:0] lc;
  logic [8:0] base;

  ////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states; ce_i low stretches every access
  assign pready_o = ce_i;
  assign apb_wr = psel_i && penable_i && pwrite_i && ce_i;
  assign ctrl_wr = apb_wr && paddr_i == OFS_CTRL;
  assign idle_go = ctrl_wr && st_r == ST_IDLE;

  always_comb begin
    prdata_o = 32'h0000_0000;
    pslverr_o = 1'b0;
    case (paddr_i)
      OFS_CTRL: prdata_o[B_ARST] = arst_in_r;
      OFS_CFG: prdata_o = {15'h0000, wdata_r, 1'b0, param_r, type_r};
      OFS_STAT: prdata_o = {30'h0000_0000, rom_active_o, st_r != ST_IDLE};
      OFS_DATA: prdata_o = {23'h00_0000, dout_r};
      default: pslverr_o = psel_i && penable_i;
    endcase
  end

  // Selector and data are frozen while an operation is running
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      type_r <= 4'h0;
      param_r <= 3'h0;
      wdata_r <= 9'h000;
      arst_in_r <= 1'b0;
    end else if (apb_wr) begin
      if (paddr_i == OFS_CFG && st_r == ST_IDLE) begin
        type_r <= pwdata_i[F_TYPE +: 4];
        param_r <= pwdata_i[F_PARAM +: 3];
        wdata_r <= pwdata_i[F_DATA +: 9];
      end
      if (paddr_i == OFS_CTRL)
        arst_in_r <= pwdata_i[B_ARST];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Operation sequencer
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_r <= ST_IDLE;
      cnt_r <= 9'h000;
      tail_r <= 2'h0;
    end else if (ce_i) begin
      case (st_r)
        ST_IDLE: begin
          if (INIT_FROM_ROM && !pu_done_r)
            st_r <= ST_ROM;
          else if (idle_go && pwdata_i[B_RD])
            st_r <= ST_RD;
          else if (idle_go && pwdata_i[B_WR])
            st_r <= ST_WR;
          else if (idle_go && pwdata_i[B_APPLY]) begin
            st_r <= ST_SHIFT;
            cnt_r <= LEN;
          end else if (idle_go && pwdata_i[B_ROM])
            st_r <= ST_ROM;
        end
        ST_RD, ST_WR: st_r <= ST_IDLE;
        ST_SHIFT: begin
          if (scanclk_r) begin
            if (cnt_r == 9'h000)
              st_r <= ST_UPD;
            else
              cnt_r <= cnt_r - 9'h001;
          end
        end
        ST_UPD: st_r <= ST_WAITD;
        ST_WAITD: if (done_s2_r && !done_s3_r) st_r <= ST_RST;
        ST_RST: st_r <= ST_IDLE;
        ST_ROM: begin
          if (rom_ptr_r == LEN) begin
            st_r <= ST_TAIL;
            tail_r <= ROM_LAT;
          end
        end
        ST_TAIL: begin
          // Data stays valid two clocks after fetch ends
          tail_r <= tail_r - 2'h1;
          if (tail_r == 2'h1)
            st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Power-up flag is not reset so a later reset does not refill from ROM
  always_ff @(posedge sys_clk_i) begin
    if (ce_i && st_r == ST_TAIL && tail_r == 2'h1)
      pu_done_r <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // ROM address generator
  assign rom_active_o = st_r == ST_ROM;
  assign rom_addr_o = rom_ptr_r;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rom_ptr_r <= 9'h000;
      restart_pend_r <= 1'b0;
    end else if (ce_i) begin
      if (st_r == ST_ROM && rom_ptr_r != LEN)
        rom_ptr_r <= rom_ptr_r + 9'h001;
      else
        rom_ptr_r <= 9'h000;
      restart_pend_r <= ctrl_wr && pwdata_i[B_RESTART];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      addr_d1_r <= 9'h000;
      addr_d2_r <= 9'h000;
      vld_d1_r <= 1'b0;
      vld_d2_r <= 1'b0;
    end else if (ce_i) begin
      addr_d1_r <= rom_ptr_r;
      addr_d2_r <= addr_d1_r;
      vld_d1_r <= rom_active_o && rom_ptr_r < LEN && !restart_pend_r;
      vld_d2_r <= vld_d1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field access
  assign dec = decode(type_r, param_r);
  assign nom_op = FAMILY == FAM_NEW && param_r == 3'h7;
  assign base = 9'((type_r * SLOT_W));
  assign hc = 9'((({1'b0, wdata_r} + 10'h001) >> 1));
  assign lc = wdata_r - hc;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cache_r <= CACHE_INIT;
    end else if (ce_i) begin
      if (vld_d2_r)
        cache_r[addr_d2_r] <= rom_data_i;
      if (st_r == ST_WR && dec[13]) begin
        if (nom_op) begin
          cache_r[base + OF_P0 +: 8] <= hc[7:0];
          cache_r[base + OF_P1 +: 8] <= lc[7:0];
          cache_r[base + OF_P5] <= wdata_r[0];
          cache_r[base + OF_P4] <= wdata_r == 9'h001;
        end else begin
          for (int i = 0; i < 9; i++)
            if (4'(i) < dec[3:0])
              cache_r[9'(dec[12:4] + 9'(i))] <= wdata_r[i];
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      dout_r <= 9'h000;
    end else if (ce_i && st_r == ST_RD) begin
      dout_r <= 9'h000;
      if (dec[13] && nom_op)
        dout_r <= {1'b0, cache_r[base + OF_P0 +: 8]} + {1'b0, cache_r[base + OF_P1 +: 8]};
      else if (dec[13])
        for (int i = 0; i < 9; i++)
          if (4'(i) < dec[3:0])
            dout_r[i] <= cache_r[9'(dec[12:4] + 9'(i))];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Scan shifter: MSB of the chain first, data moves on scan clock fall
  assign pll_scandata_o = scandata_r;
  assign pll_scanclk_o = scanclk_r;
  assign pll_scanclkena_o = st_r == ST_SHIFT;
  assign pll_configupdate_o = st_r == ST_UPD;
  assign pll_areset_o = areset_r || arst_in_r;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      scanclk_r <= 1'b0;
      scandata_r <= 1'b0;
    end else if (ce_i) begin
      if (st_r == ST_SHIFT) begin
        scanclk_r <= !scanclk_r;
        if (scanclk_r && cnt_r != 9'h000)
          scandata_r <= cache_r[cnt_r - 9'h001];
      end else begin
        scanclk_r <= 1'b1;
      end
    end
  end

  // Scandone comes from the PLL's own domain
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
      done_s3_r <= 1'b0;
      areset_r <= 1'b0;
    end else if (ce_i) begin
      done_s1_r <= pll_scandone_i;
      done_s2_r <= done_s1_r;
      done_s3_r <= done_s2_r;
      areset_r <= st_r == ST_WAITD && done_s2_r && !done_s3_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  AST_SCAN_QUIET: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $changed(pll_scandata_o) |-> $past(st_r) == ST_SHIFT)
    else $error("scan data moved outside apply");

  AST_ROM_START: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    idle_go && pwdata_i[B_ROM] && pwdata_i[2:0] == 3'h0 && (pu_done_r || !INIT_FROM_ROM)
    |=> rom_active_o)
    else $error("fetch active did not follow ROM request");

  AST_ROM_ZERO: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(rom_active_o) |-> rom_addr_o == 9'h000)
    else $error("ROM load did not start at zero");

  AST_ROM_STEP: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    rom_active_o && ce_i && rom_addr_o != LEN |=> rom_addr_o == $past(rom_addr_o) + 9'h001)
    else $error("ROM address not advanced by one");

  AST_ROM_END: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(rom_active_o) |-> $past(rom_addr_o) == LEN)
    else $error("ROM load ended at wrong address");

  AST_ROM_IDLE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !rom_active_o |-> rom_addr_o == 9'h000)
    else $error("ROM address moving while inactive");

  AST_BUSY_RISE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    idle_go && pwdata_i[B_APPLY] && pwdata_i[1:0] == 2'h0 && (pu_done_r || !INIT_FROM_ROM)
    |=> st_r == ST_SHIFT ##1 st_r != ST_IDLE)
    else $error("busy not raised after apply");

  AST_ILLEGAL_ZERO: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    st_r == ST_RD && ce_i && !dec[13] |=> dout_r == 9'h000)
    else $error("illegal selector read not zero");

  AST_NOM_SPLIT: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    st_r == ST_WR && ce_i && nom_op && dec[13] && !vld_d2_r
    |=> cache_r[base + OF_P0 +: 8] == 8'($past(hc)) && cache_r[base + OF_P5] == $past(wdata_r[0]))
    else $error("nominal count split wrong");

endmodule // pscr_top
`default_nettype wire

// [pscr_far_model.sv]
// Far-side model: serial configuration ROM and the PLL scan port.
// Assumes everything runs on sys_clk_i; the ROM image comes from the bench.
`timescale 1ns/1ps
`default_nettype none
module pscr_far_model (
  // Clock
  input wire logic sys_clk_i,
  // Serial ROM
  input wire logic [511:0] rom_img_i,
  input wire logic [8:0] rom_addr_i,
  input wire logic rom_active_i,
  output logic rom_data_o,
  // PLL scan port
  input wire logic scanclk_i,
  input wire logic scanclkena_i,
  input wire logic scandata_i,
  input wire logic configupdate_i,
  input wire logic [7:0] done_dly_i,
  output logic scandone_o,
  output logic [383:0] chain_o,
  output logic [8:0] nbits_o
);
  logic [1:0] pipe_r = 2'h0;
  logic [1:0] pipe2_r = 2'h0;
  logic tail_r = 1'h0;
  logic junk_r = 1'h0;
  logic sc_q = 1'h1;
  logic ena_q = 1'h0;
  logic [7:0] wait_r = 8'h00;
  initial scandone_o = 1'h0;
  initial chain_o = '0;
  initial nbits_o = 9'h000;
  ////////////////////////////////////////////////////////////////
  // Outside the valid window the line wanders so stale bits are not trusted
  always @(posedge sys_clk_i) begin
    // Two stages: the bit for an address shows two clocks after that address
    pipe_r <= {rom_active_i, rom_img_i[rom_addr_i]};
    pipe2_r <= pipe_r;
    tail_r <= pipe2_r[1];
    junk_r <= ~junk_r;
  end
  assign rom_data_o = (pipe2_r[1] | tail_r) ? pipe2_r[0] : junk_r;
  ////////////////////////////////////////////////////////////////
  // Chain capture on scan clock rise; done comes back after a set delay
  always @(posedge sys_clk_i) begin
    sc_q <= scanclk_i;
    ena_q <= scanclkena_i;
    if (scanclkena_i && scanclk_i && !sc_q) begin
      chain_o <= {chain_o[382:0], scandata_i};
      nbits_o <= (ena_q ? nbits_o : 9'h000) + 9'h001;
    end else if (scanclkena_i && !ena_q) begin
      nbits_o <= 9'h000;
    end
    if (configupdate_i) begin
      scandone_o <= 1'h0;
      wait_r <= done_dly_i;
    end else if (wait_r != 8'h00) begin
      wait_r <= wait_r - 8'h01;
      if (wait_r == 8'h01) begin
        scandone_o <= 1'h1;
      end
    end
  end
endmodule // pscr_far_model
`default_nettype wire

// [tb_top.sv]
// Self-checking bench: APB traffic, ROM load and apply with monitors.
// Assumes pscr_top in the newer family, low-cost variant, with the far model.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pscr_pkg::*;
  localparam int LEN = 144;
  localparam logic [2:0] PS [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h7};
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sdata, sclk, sena, cupd, areset, sdone, rdata, ractive;
  logic [8:0] raddr, nbits, v;
  logic [383:0] chain;
  logic [511:0] img = '0;
  logic [7:0] dly = 8'h03;
  logic [7:0] lv [9];
  logic [31:0] seed = 32'h9566;
  logic [31:0] q;
  logic last_err = 1'h0, applying = 1'h0, sd_q = 1'h0, ar_q = 1'h0;
  logic [9:0] exp_a = 10'h000;
  int fails = 0, n_tests = 0, nrst = 0;
  always #50 sys_clk = ~sys_clk;
  pscr_top #(.FAMILY(FAM_NEW), .VARIANT(VAR_LOW)) dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
    .ce_i(1'h1), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .pll_scandata_o(sdata), .pll_scanclk_o(sclk), .pll_scanclkena_o(sena),
    .pll_configupdate_o(cupd), .pll_areset_o(areset), .pll_scandone_i(sdone),
    .rom_data_i(rdata), .rom_addr_o(raddr), .rom_active_o(ractive));
  pscr_far_model u_far (.sys_clk_i(sys_clk), .rom_img_i(img), .rom_addr_i(raddr),
    .rom_active_i(ractive), .rom_data_o(rdata), .scanclk_i(sclk), .scanclkena_i(sena),
    .scandata_i(sdata), .configupdate_i(cupd), .done_dly_i(dly), .scandone_o(sdone),
    .chain_o(chain), .nbits_o(nbits));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] nom(input logic [8:0] n, input logic [2:0] p);
    logic [8:0] h;
    h = n[0] ? (n + 9'h001) >> 1 : n >> 1;
    case (p)
      3'h0: return 32'(h);
      3'h1: return 32'(n - h);
      3'h4: return 32'(n == 9'h001);
      3'h5: return 32'(n[0]);
      default: return 32'(n);
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Holds the request until pready is sampled high; data taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    @(posedge sys_clk);
    k = 0;
    while (pready !== 1'h1 && k < 100) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 100) fails++;
    q = prdata;
    last_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      apb(1'h0, OFS_STAT, 32'h0);
      k++;
    end while (q[0] !== 1'h0 && k < 500);
    if (k >= 500) fails++;
  endtask
  task automatic op(input logic [3:0] t, input logic [2:0] p, input logic [8:0] d, input int b);
    apb(1'h1, OFS_CFG, {15'h0, d, 1'h0, p, t});
    apb(1'h1, OFS_CTRL, 32'h1 << b);
    wait_idle();
    if (b == B_RD) apb(1'h0, OFS_DATA, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  // Monitors: ROM address walk, idle scan data, reset pulses to the PLL
  always @(posedge sys_clk) begin
    if (rst_n) begin
      if (ractive === 1'h1) begin
        chk("rom_addr", 32'(raddr), 32'(exp_a));
        exp_a = exp_a + 10'h001;
      end else if (exp_a != 10'h000) begin
        chk("rom_len", 32'(exp_a), LEN + 1);
        exp_a = 10'h000;
      end
      chk("scandata_idle", 32'(sdata !== sd_q && !applying), 32'h0);
      if (areset && !ar_q) nrst++;
    end
    sd_q <= sdata;
    ar_q <= areset;
  end
  initial begin
    #5_000_000;
    fails++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 16; i++) img[i*32 +: 32] = xs();
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'h1;
    chk("active_rst", 32'(ractive), 32'h0);
    op(4'h4, 3'h0, 9'h000, B_RD);
    chk("cache_init", q, 32'h0);
    apb(1'h0, 8'h10, 32'h0);
    chk("unmapped", 32'(last_err), 32'h1);
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 9'h001 : (i == 1) ? 9'h002 : (i == 2) ? 9'h1FD : 9'(xs() % 509 + 1);
      op(4'h1, 3'h7, v, B_WR);
      foreach (PS[j]) begin
        op(4'h1, PS[j], 9'h000, B_RD);
        chk("nominal", q, nom(v, PS[j]));
      end
    end
    op(4'hE, 3'h0, 9'h055, B_WR);
    op(4'hE, 3'h0, 9'h000, B_RD);
    chk("illegal_rd", q, 32'h0);
    op(4'h1, 3'h0, 9'h000, B_RD);
    chk("illegal_wr", q, nom(v, 3'h0));
    for (int t = 0; t < 9; t++) lv[t] = 8'(xs());
    // Direct writes leave the odd bit of M and N alone
    for (int t = 0; t < 9; t++)
      if (t != 2 && t != 3) op(4'(t), 3'h1, {1'h0, lv[t]}, B_WR);
    for (int t = 0; t < 9; t++) begin
      if (t != 2 && t != 3) begin
        op(4'(t), 3'h1, 9'h000, B_RD);
        chk("decode", q, 32'(lv[t]));
      end
    end
    apb(1'h1, OFS_CTRL, 32'h1 << B_ARST);
    @(posedge sys_clk);
    chk("areset_lvl", 32'(areset), 32'h1);
    apb(1'h1, OFS_CTRL, 32'h0);
    apb(1'h1, OFS_CTRL, 32'h1 << B_RESTART);
    apb(1'h1, OFS_CTRL, 32'h1 << B_ROM);
    @(posedge sys_clk);
    chk("rom_start", {22'h0, ractive, raddr}, 32'h200);
    wait_idle();
    for (int t = 0; t < 6; t++) begin
      for (int p = 0; p < 2; p++) begin
        if (t != 2 && t != 3) begin
          op(4'(t), 3'(p), 9'h000, B_RD);
          chk("rom_fill", q, 32'(img[t*24 + p*9 +: 8]));
        end
      end
    end
    for (int r = 0; r < 2; r++) begin
      dly <= (r == 0) ? 8'h03 : 8'h28;
      nrst = 0;
      applying = 1'h1;
      apb(1'h1, OFS_CTRL, 32'h1 << B_APPLY);
      apb(1'h0, OFS_STAT, 32'h0);
      chk("busy", 32'(q[0]), 32'h1);
      wait_idle();
      applying = 1'h0;
      chk("nbits", 32'(nbits), LEN);
      chk("chain", 32'(chain[96 +: 18]), 32'(img[96 +: 18]));
      chk("areset_pulse", 32'(nrst), 32'h1);
    end
    // Mid-run reset: cache returns to its image and no ROM refill starts
    @(posedge sys_clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'h1;
    apb(1'h0, OFS_STAT, 32'h0);
    chk("no_refill", q, 32'h0);
    op(4'h1, 3'h0, 9'h000, B_RD);
    chk("cache_rst", q, 32'h0);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
